// ==== rtl/sdram_cfg_defines.svh ====
`ifndef SDRAM_CFG_DEFINES_SVH
`define SDRAM_CFG_DEFINES_SVH

// register byte offsets
`define MEM_CFG_OFS 12'h000
`define REFRESH_OFS 12'h004
`define CTRL_OFS 12'h008

// memory configuration fields
`define CHIPS_MSB 22
`define CHIPS_LSB 21
`define QOS_MSB 20
`define QOS_LSB 18
`define BURST_MSB 17
`define BURST_LSB 15
`define CLK_STOP_BIT 14
`define PWR_DOWN_BIT 13
`define PD_CYC_MSB 12
`define PD_CYC_LSB 7
`define AP_POS_BIT 6
`define ROW_MSB 5
`define ROW_LSB 3
`define COL_MSB 2
`define COL_LSB 0

// refresh interval field
`define REFRESH_MSB 14

// reset values
`define MEM_CFG_RESET 32'h0000_0000
`define REFRESH_RESET 15'h0000

// control commands, written to ctrl bits [1:0]
`define CMD_GO 2'h0
`define CMD_CONFIG 2'h1
`define CMD_SLEEP 2'h2
`define CMD_WAKE 2'h3

`endif

// ==== rtl/sdram_cfg_pkg.sv ====
package sdram_cfg_pkg;

    // controller operating states, one-hot
    typedef enum logic [2:0] {
        ST_CONFIG = 3'b001,
        ST_READY = 3'b010,
        ST_LOW_POWER = 3'b100
    } ctrl_state_t;

endpackage

// ==== rtl/sdram_cfg_refresh.sv ====
// What this block does
// - refresh goes to one, two, three or four chips by chip select code.
// - never command more chips than the built chip count allows.
// - read qos comes from a four-bit arid window picked by code.
// - burst code picks 1, 2, 4, 8 or 16 accesses per command.
// - with clock gating on, stop memory clock while no access runs and no refresh is due.
// - with idle power-down on, drop cke after fifo empty long enough.
// - idle power-down delay is a six-bit cycle count in bits 12:7.
// - auto-precharge flag sits on address bit 10, or 8 when set.
// - row address is 11 to 16 bits for codes 0 to 5.
// - column address is 8 to 12 bits for codes 0 to 4.
// - refresh interval is a 15-bit cycle count, any value allowed.
// - refresh register bits 31:15 read undefined, written as zero.
// - refresh register accessible only in config or low power state.
// - config register accessible only in config or low power state.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "sdram_cfg_defines.svh"

module sdram_cfg_refresh
    import sdram_cfg_pkg::*;
#(
    parameter int MEMORY_CHIPS = 4,
    parameter int ARID_W = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // axi read side
    input wire logic [ARID_W-1:0] arid_i,
    output logic [3:0] qos_sel_o,
    // memory engine side
    input wire logic access_busy_i,
    input wire logic cmd_fifo_empty_i,
    output logic [3:0] refresh_chip_o,
    output logic mem_clk_en_o,
    output logic cke_o,
    output logic [4:0] burst_beats_o,
    output logic [3:0] precharge_addr_bit_o,
    output logic [4:0] row_bits_o,
    output logic [3:0] col_bits_o
);

    // refuse configurations the logic cannot serve
    if (MEMORY_CHIPS < 1 || MEMORY_CHIPS > 4) begin : g_chk_chips
        $error("MEMORY_CHIPS must be 1 to 4");
    end
    if (ARID_W < 8) begin : g_chk_arid
        $error("ARID_W must be at least 8");
    end

    localparam logic [2:0] BUILT_CHIPS = 3'(MEMORY_CHIPS);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // state
    ctrl_state_t state, next_state;
    logic [31:0] mem_cfg, next_mem_cfg, next_prdata;
    logic [14:0] refresh_ival, next_refresh_ival, ref_cnt, next_ref_cnt;
    logic [5:0] idle_cnt, next_idle_cnt;
    logic next_cke, next_clk_en;
    logic [3:0] next_refresh_chip, next_qos, next_precharge_pos, next_col;
    logic [4:0] next_burst, next_row;

    // decode helpers
    logic setup, access, hit_cfg, hit_ref, hit_ctrl, cfg_open, refused;
    logic refresh_due;
    logic [2:0] eff_chips, qos_code, burst_code, row_code, col_code;
    logic [3:0] chip_mask, arid_lo;
    logic [5:0] pd_cycles;
    logic [14:0] wdata_lo;

    // field views of the configuration register
    assign qos_code = mem_cfg[`QOS_MSB:`QOS_LSB];
    assign burst_code = mem_cfg[`BURST_MSB:`BURST_LSB];
    assign row_code = mem_cfg[`ROW_MSB:`ROW_LSB];
    assign col_code = mem_cfg[`COL_MSB:`COL_LSB];
    assign pd_cycles = mem_cfg[`PD_CYC_MSB:`PD_CYC_LSB];
    assign wdata_lo = pwdata_i[`REFRESH_MSB:0];
    assign arid_lo = arid_i[3:0];

    // apb phase and address decode
    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign hit_cfg = paddr_i == `MEM_CFG_OFS;
    assign hit_ref = paddr_i == `REFRESH_OFS;
    assign hit_ctrl = paddr_i == `CTRL_OFS;
    assign cfg_open = (state == ST_CONFIG) || (state == ST_LOW_POWER);
    assign refused = (hit_cfg | hit_ref) & ~cfg_open;

    // zero wait states; error on unmapped or locked register
    assign pready_o = 1'b1;
    assign pslverr_o = access & (refused | ~(hit_cfg | hit_ref | hit_ctrl));

    // active chips, clamped to the built chip count
    always_comb begin
        eff_chips = {1'b0, mem_cfg[`CHIPS_MSB:`CHIPS_LSB]} + 3'h1;
        if (eff_chips > BUILT_CHIPS) begin
            eff_chips = BUILT_CHIPS;
        end
        case (eff_chips)
            3'h1: chip_mask = 4'h1;
            3'h2: chip_mask = 4'h3;
            3'h3: chip_mask = 4'h7;
            3'h4: chip_mask = 4'hf;
            default: chip_mask = 4'h1;
        endcase
    end

    // refresh falls due when the count reaches one below the interval
    assign refresh_due = (state == ST_READY) && (refresh_ival != 15'h0000)
        && (ref_cnt >= refresh_ival - 15'h0001);

    // register writes, state commands and read data
    always_comb begin
        next_mem_cfg = mem_cfg;
        next_refresh_ival = refresh_ival;
        next_state = state;
        next_prdata = prdata_o;
        if (access && pwrite_i && hit_cfg && cfg_open) begin
            next_mem_cfg = pwdata_i;
        end
        if (access && pwrite_i && hit_ref && cfg_open) begin
            next_refresh_ival = wdata_lo;
        end
        if (access && pwrite_i && hit_ctrl) begin
            case (pwdata_i[1:0])
                `CMD_GO: begin
                    if (state == ST_CONFIG) begin
                        next_state = ST_READY;
                    end
                end
                `CMD_CONFIG: begin
                    if (state == ST_READY) begin
                        next_state = ST_CONFIG;
                    end
                end
                `CMD_SLEEP: begin
                    if (state == ST_READY) begin
                        next_state = ST_LOW_POWER;
                    end
                end
                `CMD_WAKE: begin
                    if (state == ST_LOW_POWER) begin
                        next_state = ST_READY;
                    end
                end
                default: next_state = state;
            endcase
        end
        // read data is fetched in the setup cycle
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (hit_cfg && cfg_open) begin
                next_prdata = mem_cfg;
            end else if (hit_ref && cfg_open) begin
                next_prdata = {17'h00000, refresh_ival};
            end else if (hit_ctrl) begin
                next_prdata = {24'h000000, mem_clk_en_o, cke_o,
                    BUILT_CHIPS[1:0] - 2'h1, 1'b0, state};
            end
        end
    end

    // register bank
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state <= ST_CONFIG;
            mem_cfg <= `MEM_CFG_RESET;
            refresh_ival <= `REFRESH_RESET;
            prdata_o <= 32'h0000_0000;
        end else begin
            state <= next_state;
            mem_cfg <= next_mem_cfg;
            refresh_ival <= next_refresh_ival;
            prdata_o <= next_prdata;
        end
    end

    // refresh timer, idle power-down and clock gating
    always_comb begin
        next_ref_cnt = ref_cnt;
        next_refresh_chip = 4'h0;
        next_idle_cnt = idle_cnt;
        next_cke = cke_o;
        if (state != ST_READY) begin
            next_ref_cnt = 15'h0000;
        end else if (refresh_due) begin
            next_ref_cnt = 15'h0000;
            next_refresh_chip = chip_mask;
        end else begin
            next_ref_cnt = ref_cnt + 15'h0001;
        end
        case (state)
            ST_CONFIG: begin
                next_idle_cnt = 6'h00;
                next_cke = 1'b1;
            end
            ST_LOW_POWER: begin
                next_idle_cnt = 6'h00;
                next_cke = 1'b0;
            end
            ST_READY: begin
                if (!mem_cfg[`PWR_DOWN_BIT] || !cmd_fifo_empty_i
                    || refresh_due) begin
                    next_idle_cnt = 6'h00;
                    next_cke = 1'b1;
                end else if (idle_cnt >= pd_cycles) begin
                    next_cke = 1'b0;
                end else begin
                    next_idle_cnt = idle_cnt + 6'h01;
                end
            end
            default: begin
                next_idle_cnt = 6'h00;
                next_cke = 1'b1;
            end
        endcase
        // with clock gating on, memory clock runs for accesses and refreshes only
        next_clk_en = !mem_cfg[`CLK_STOP_BIT] || access_busy_i
            || refresh_due;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ref_cnt <= 15'h0000;
            refresh_chip_o <= 4'h0;
            idle_cnt <= 6'h00;
            cke_o <= 1'b1;
            mem_clk_en_o <= 1'b1;
        end else begin
            ref_cnt <= next_ref_cnt;
            refresh_chip_o <= next_refresh_chip;
            idle_cnt <= next_idle_cnt;
            cke_o <= next_cke;
            mem_clk_en_o <= next_clk_en;
        end
    end

    // decoded settings for the memory engine
    always_comb begin
        case (qos_code)
            3'h1: next_qos = arid_i[4:1];
            3'h2: next_qos = arid_i[5:2];
            3'h3: next_qos = arid_i[6:3];
            3'h4: next_qos = arid_i[7:4];
            default: next_qos = arid_i[3:0];
        endcase
        case (burst_code)
            3'h1: next_burst = 5'h02;
            3'h2: next_burst = 5'h04;
            3'h3: next_burst = 5'h08;
            3'h4: next_burst = 5'h10;
            default: next_burst = 5'h01;
        endcase
        next_precharge_pos = mem_cfg[`AP_POS_BIT] ? 4'h8 : 4'ha;
        case (row_code)
            3'h1: next_row = 5'h0c;
            3'h2: next_row = 5'h0d;
            3'h3: next_row = 5'h0e;
            3'h4: next_row = 5'h0f;
            3'h5: next_row = 5'h10;
            default: next_row = 5'h0b;
        endcase
        case (col_code)
            3'h1: next_col = 4'h9;
            3'h2: next_col = 4'ha;
            3'h3: next_col = 4'hb;
            3'h4: next_col = 4'hc;
            default: next_col = 4'h8;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            qos_sel_o <= 4'h0;
            burst_beats_o <= 5'h01;
            precharge_addr_bit_o <= 4'ha;
            row_bits_o <= 5'h0b;
            col_bits_o <= 4'h8;
        end else begin
            qos_sel_o <= next_qos;
            burst_beats_o <= next_burst;
            precharge_addr_bit_o <= next_precharge_pos;
            row_bits_o <= next_row;
            col_bits_o <= next_col;
        end
    end

    // locked configuration register keeps its value
    a_cfg_write_locked: assert property (
        access && pwrite_i && hit_cfg && !cfg_open
        |=> mem_cfg == $past(mem_cfg))
        else $error("config register changed while locked");
    // accepted refresh write stores the low 15 bits
    a_refresh_write_taken: assert property (
        access && pwrite_i && hit_ref && cfg_open
        |=> refresh_ival == $past(wdata_lo))
        else $error("refresh interval not stored");
    // locked refresh register ignores writes
    a_refresh_write_locked: assert property (
        access && pwrite_i && hit_ref && !cfg_open
        |=> $stable(refresh_ival))
        else $error("refresh interval changed while locked");
    // refresh strobe width equals active chips
    a_refresh_chip_count: assert property (
        refresh_chip_o != 4'h0
        |-> $countones(refresh_chip_o) == 32'($past(eff_chips)))
        else $error("wrong number of chips refreshed");
    // no chip beyond the built count is refreshed
    a_refresh_chip_limit: assert property (
        $countones(refresh_chip_o) <= MEMORY_CHIPS)
        else $error("refresh beyond built chips");
    // two refreshes are one interval apart
    a_refresh_spacing: assert property (
        refresh_chip_o != 4'h0 && refresh_ival == 15'h0003
        && state == ST_READY ##1 state == ST_READY [*3]
        |-> refresh_chip_o != 4'h0)
        else $error("refresh interval not kept");
    // qos window at code zero follows arid bits 3:0
    a_qos_window: assert property (
        qos_code == 3'h0 |=> qos_sel_o == $past(arid_lo))
        else $error("qos window wrong");
    // burst length doubles per code, output lags the code by one cycle
    a_burst_map: assert property (
        burst_code <= 3'h4 && $stable(burst_code)
        |=> burst_beats_o == 5'(5'h01 << $past(burst_code)))
        else $error("burst length wrong");
    // clock never stops while gating is off
    a_clock_free: assert property (
        !mem_cfg[`CLK_STOP_BIT] |=> mem_clk_en_o)
        else $error("memory clock stopped without gating");
    // cke falls in ready only after the full idle delay
    a_powerdown_delay: assert property (
        $fell(cke_o) && state == ST_READY |-> idle_cnt >= pd_cycles
        && $past(cmd_fifo_empty_i))
        else $error("cke dropped too early");
    // precharge flag position follows the flag bit
    a_precharge_pos: assert property (
        ##1 precharge_addr_bit_o == ($past(mem_cfg[`AP_POS_BIT])
        ? 4'h8 : 4'ha))
        else $error("precharge bit position wrong");
    // row width range 11 to 16
    a_row_width: assert property (
        row_code == 3'h5 && $stable(row_code) |=> row_bits_o == 5'h10)
        else $error("row width wrong");
    // column width range 8 to 12
    a_col_width: assert property (
        col_code == 3'h4 && $stable(col_code) |=> col_bits_o == 4'hc)
        else $error("column width wrong");

endmodule

// ==== tb/mem_engine_model.sv ====
`timescale 1ns/1ns
module mem_engine_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // request from the bench
    input wire logic start_i,
    input wire logic [7:0] len_i,
    // engine status seen by the controller
    output logic access_busy_o,
    output logic fifo_empty_o
);
    logic [7:0] left;

    // a queued command sits in the fifo one cycle, then runs len_i cycles
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            left <= 8'h00;
            fifo_empty_o <= 1'b1;
            access_busy_o <= 1'b0;
        end else if (start_i) begin
            fifo_empty_o <= 1'b0;
            left <= len_i;
        end else if (left != 8'h00) begin
            fifo_empty_o <= 1'b1;
            access_busy_o <= 1'b1;
            left <= left - 8'h01;
        end else begin
            access_busy_o <= 1'b0;
        end
    end
endmodule

// ==== tb/sdram_cfg_refresh_tb.sv ====
`timescale 1ns/1ns
`include "sdram_cfg_defines.svh"
module sdram_cfg_refresh_tb;
    import sdram_cfg_pkg::*;
    localparam int CHIPS = 3;
    logic core_clk, rstn, psel, penable, pwrite, start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, rerr, busy, fempty, clk_en, cke;
    logic [7:0] arid, len;
    logic [3:0] qos, chip, apb;
    logic [4:0] burst, row;
    logic [3:0] col;
    int n_errors = 0;
    int check_count = 0;
    int n;

    sdram_cfg_refresh #(.MEMORY_CHIPS(CHIPS), .ARID_W(8)) u_dut (
        .core_clk_i(core_clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .arid_i(arid), .qos_sel_o(qos),
        .access_busy_i(busy), .cmd_fifo_empty_i(fempty),
        .refresh_chip_o(chip), .mem_clk_en_o(clk_en), .cke_o(cke),
        .burst_beats_o(burst), .precharge_addr_bit_o(apb),
        .row_bits_o(row), .col_bits_o(col));

    mem_engine_model u_engine (
        .clk_i(core_clk), .rstn_i(rstn), .start_i(start), .len_i(len),
        .access_busy_o(busy), .fifo_empty_o(fempty));

    // free running bench clock, 8 ns period
    always #4 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // answer and read data are taken at the edge that sees pready
        for (k = 0; k < 16; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 16) begin
            n_errors++;
            print_verdict();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic e);
        xfer(1'b1, a, d);
        check("write error", {31'h0, rerr}, {31'h0, e});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic e);
        xfer(1'b0, a, 32'h0);
        check("read data", rdata, x);
        check("read error", {31'h0, rerr}, {31'h0, e});
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // launch one engine access from the partner
    task automatic engine_go(input logic [7:0] l);
        @(posedge core_clk);
        start <= 1'b1;
        len <= l;
        @(posedge core_clk);
        start <= 1'b0;
    endtask

    initial begin
        core_clk = 1'b0;
        rstn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        arid <= 8'hb4;
        start <= 1'b0;
        len <= 8'h00;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        // reset values and status
        rd(`MEM_CFG_OFS, 32'h0, 1'b0);
        rd(`REFRESH_OFS, 32'h0, 1'b0);
        rd(`CTRL_OFS, 32'h0000_00e1, 1'b0);
        // every code of the decoded fields, reserved ones included
        for (int i = 0; i < 8; i++) begin
            wr(`MEM_CFG_OFS, (i << 18) | (i << 15) | ((i & 1) << 6)
               | (i << 3) | i, 1'b0);
            rd(`MEM_CFG_OFS, (i << 18) | (i << 15) | ((i & 1) << 6)
               | (i << 3) | i, 1'b0);
            cycles(2);
            check("burst", burst, i < 5 ? 1 << i : 1);
            check("row", row, i < 6 ? 11 + i : 11);
            check("col", col, i < 5 ? 8 + i : 8);
            check("ap", apb, i[0] ? 8 : 10);
            check("qos", qos, i < 5 ? (8'hb4 >> i) & 8'h0f : 4);
        end
        // refresh interval width and upper bits
        wr(`REFRESH_OFS, 32'h0000_7fff, 1'b0);
        rd(`REFRESH_OFS, 32'h0000_7fff, 1'b0);
        // chip mask and period per chip code, clipped to built count
        for (int c = 0; c < 4; c++) begin
            wr(`MEM_CFG_OFS, c << 21, 1'b0);
            wr(`REFRESH_OFS, 32'h3, 1'b0);
            wr(`CTRL_OFS, `CMD_GO, 1'b0);
            for (n = 0; n < 10 && chip === 4'h0; n++)
                @(negedge core_clk);
            check("mask", chip, c < 2 ? (1 << (c + 1)) - 1 : 7);
            cycles(1);
            check("gap", chip, 0);
            cycles(1);
            check("gap", chip, 0);
            cycles(1);
            check("mask", chip, c < 2 ? (1 << (c + 1)) - 1 : 7);
            // registers locked while running
            wr(`MEM_CFG_OFS, 32'h0, 1'b1);
            rd(`REFRESH_OFS, 32'h0, 1'b1);
            wr(`CTRL_OFS, `CMD_CONFIG, 1'b0);
        end
        rd(`MEM_CFG_OFS, 32'h0060_0000, 1'b0);
        rd(12'h00c, 32'h0, 1'b1);
        // clock gating with refresh off
        wr(`REFRESH_OFS, 32'h0, 1'b0);
        wr(`MEM_CFG_OFS, 32'h0000_4000, 1'b0);
        wr(`CTRL_OFS, `CMD_GO, 1'b0);
        cycles(3);
        check("clk stop", clk_en, 0);
        engine_go(8'h04);
        cycles(3);
        check("clk run", clk_en, 1);
        cycles(8);
        check("clk stop", clk_en, 0);
        wr(`CTRL_OFS, `CMD_CONFIG, 1'b0);
        // idle power-down after five empty cycles, above read latency
        wr(`MEM_CFG_OFS, 32'h0000_2000 | (5 << 7), 1'b0);
        wr(`CTRL_OFS, `CMD_GO, 1'b0);
        for (n = 0; n < 20 && cke !== 1'b0; n++)
            @(negedge core_clk);
        check("pd delay", n, 7);
        check("cke", cke, 0);
        engine_go(8'h02);
        cycles(1);
        check("cke wake", cke, 1);
        // low power state accepts configuration again
        wr(`CTRL_OFS, `CMD_SLEEP, 1'b0);
        cycles(2);
        check("cke sleep", cke, 0);
        wr(`REFRESH_OFS, 32'h5, 1'b0);
        rd(`REFRESH_OFS, 32'h5, 1'b0);
        wr(`MEM_CFG_OFS, 32'h0000_2000 | (6 << 7), 1'b0);
        wr(`CTRL_OFS, `CMD_WAKE, 1'b0);
        xfer(1'b0, `CTRL_OFS, 32'h0);
        check("state", rdata[2:0], ST_READY);
        print_verdict();
    end
endmodule
